// ---- hdl/sotd_map.svh ----
// Purpose: Offsets, field positions, reset values for the telegram decoder
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef SOTD_MAP_SVH
`define SOTD_MAP_SVH

// Telegram layout
`define SOTD_TEL_LEN       11
`define SOTD_LAST_IDX      4'ha
`define SOTD_BYTE_SEL_LO   0
`define SOTD_BYTE_SEL_HI   2
`define SOTD_BYTE_RESTART  4
`define SOTD_BYTE_STATUS   6
`define SOTD_BYTE_CRC0     7
`define SOTD_FIRST_CRC_IDX 4'h7
`define SOTD_SEL_W         5
`define SOTD_BIT_RST_WF    0
`define SOTD_BIT_RST_PF    1

// Register offsets
`define SOTD_OFS_MODE      12'h000
`define SOTD_OFS_SELECT    12'h004
`define SOTD_OFS_STATUS    12'h008
`define SOTD_OFS_CRC       12'h00c
`define SOTD_OFS_FRAMES    12'h010

// Field positions in SELECT and STATUS
`define SOTD_POS_SEL_HI    8
`define SOTD_POS_BANK      16
`define SOTD_POS_PSTAT     8
`define SOTD_POS_MODE_ERR  16

// Reset values and responses
`define SOTD_MODE_RESET    2'h0
`define SOTD_RESP_OKAY     2'h0
`define SOTD_RESP_SLVERR   2'h2

`endif

// ---- hdl/sotd_pkg.sv ----
// Purpose: Types shared by the telegram decoder
// Assumes: None
// Notes:   Mode encoding is the value software writes to MODE
package sotd_pkg;

    typedef enum logic [1:0] {
        SOTD_MODE_FIELD_PAIRS = 2'h0,
        SOTD_MODE_HUNDRED     = 2'h1,
        SOTD_MODE_MULTI_CFG   = 2'h2,
        SOTD_MODE_INVALID     = 2'h3
    } sotd_mode_t;

    typedef enum logic [1:0] {
        SOTD_ST_IDLE = 2'h0,
        SOTD_ST_BODY = 2'h1,
        SOTD_ST_CRC  = 2'h3
    } sotd_state_t;

    typedef logic [7:0] sotd_byte_t;

endpackage : sotd_pkg

// ---- hdl/sotd_decoder.sv ----
// Purpose: Frames and decodes the 11-byte safe output telegram
// Assumes: Byte stream synchronous to clock, first byte flagged
// Notes:   Outputs change one cycle after the last byte is taken
// Operation
// - Payload bytes decoded by configured mode
// - Eleven bytes: payload, status, CRC MSB first
// - Pair mode: byte 0 bits 0-4 select
// - Byte 4 bits 1/0 request restarts
// - Pair mode ignores bytes 1,2,3,5
// - Hundred mode: byte 0 is group one
// - Hundred mode: byte 2 is group two
// - Multi mode: byte 0 selects bank
// - Multi mode: byte 2 selects switchover
`include "sotd_map.svh"

module sotd_decoder
    import sotd_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Telegram byte stream
    input  wire logic        tel_valid,
    input  wire logic        tel_first,
    input  wire logic [7:0]  tel_data,
    // Decoded telegram
    output logic             frame_done,
    output logic [4:0]       select_low,
    output logic [4:0]       select_high,
    output logic [4:0]       bank_select,
    output logic             restart_warning,
    output logic             restart_protect,
    output logic [7:0]       profile_status,
    output logic [7:0]       crc_byte_highest,
    output logic [7:0]       crc_byte_second,
    output logic [7:0]       crc_byte_third,
    output logic [7:0]       crc_byte_lowest,
    output logic             mode_error,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Framing

    sotd_state_t state;
    sotd_state_t next_state;
    logic [3:0]  byte_cnt;
    logic        commit;
    sotd_byte_t  tel_buf [`SOTD_TEL_LEN];
    sotd_mode_t  mode;

    // A flagged first byte always restarts, so a torn frame is dropped
    wire         take_byte = tel_valid & (tel_first | (state != SOTD_ST_IDLE));
    wire [3:0]   wr_idx    = tel_first ? 4'h0 : byte_cnt;
    wire         last_byte = take_byte & (wr_idx == `SOTD_LAST_IDX);

    always_comb begin
        next_state = state;
        if (take_byte) begin
            if (last_byte) begin
                next_state = SOTD_ST_IDLE;
            end else if (wr_idx + 4'h1 >= `SOTD_FIRST_CRC_IDX) begin
                next_state = SOTD_ST_CRC;
            end else begin
                next_state = SOTD_ST_BODY;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state    <= SOTD_ST_IDLE;
            byte_cnt <= 4'h0;
            commit   <= 1'b0;
        end else begin
            state  <= next_state;
            commit <= last_byte;
            if (take_byte) begin
                byte_cnt <= last_byte ? 4'h0 : wr_idx + 4'h1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SOTD_TEL_LEN; gi++) begin : g_buf
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    tel_buf[gi] <= 8'h00;
                end else if (take_byte && wr_idx == 4'(gi)) begin
                    tel_buf[gi] <= tel_data;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Decode by mode

    // Only the low five bits are ever looked at; bits 5-7 are reserved
    wire [4:0] sel_byte_lo = tel_buf[`SOTD_BYTE_SEL_LO][`SOTD_SEL_W-1:0];
    wire [4:0] sel_byte_hi = tel_buf[`SOTD_BYTE_SEL_HI][`SOTD_SEL_W-1:0];
    wire       is_pairs    = (mode == SOTD_MODE_FIELD_PAIRS);
    wire       is_hundred  = (mode == SOTD_MODE_HUNDRED);
    wire       is_multi    = (mode == SOTD_MODE_MULTI_CFG);
    wire       is_invalid  = (mode == SOTD_MODE_INVALID);

    // Invalid mode drives every selection and request inactive (fail safe)
    wire [4:0] next_select_low  = (is_pairs | is_hundred) ? sel_byte_lo
                                                          : 5'h00;
    wire [4:0] next_select_high = (is_hundred | is_multi) ? sel_byte_hi
                                                          : 5'h00;
    wire [4:0] next_bank_select = is_multi ? sel_byte_lo : 5'h00;
    wire       next_rst_wf      = ~is_invalid
                                & tel_buf[`SOTD_BYTE_RESTART][`SOTD_BIT_RST_WF];
    wire       next_rst_pf      = ~is_invalid
                                & tel_buf[`SOTD_BYTE_RESTART][`SOTD_BIT_RST_PF];

    logic [15:0] frame_count;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            frame_done      <= 1'b0;
            select_low      <= 5'h00;
            select_high     <= 5'h00;
            bank_select     <= 5'h00;
            restart_warning <= 1'b0;
            restart_protect <= 1'b0;
            mode_error      <= 1'b0;
            frame_count     <= 16'h0000;
        end else begin
            frame_done <= commit;
            if (commit) begin
                select_low      <= next_select_low;
                select_high     <= next_select_high;
                bank_select     <= next_bank_select;
                restart_warning <= next_rst_wf;
                restart_protect <= next_rst_pf;
                mode_error      <= is_invalid;
                frame_count     <= frame_count + 16'h0001;
            end
        end
    end

    // Status and CRC pass through unchecked; checking is upstream
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            profile_status   <= 8'h00;
            crc_byte_highest <= 8'h00;
            crc_byte_second  <= 8'h00;
            crc_byte_third   <= 8'h00;
            crc_byte_lowest  <= 8'h00;
        end else if (commit) begin
            profile_status   <= tel_buf[`SOTD_BYTE_STATUS];
            crc_byte_highest <= tel_buf[`SOTD_BYTE_CRC0];
            crc_byte_second  <= tel_buf[`SOTD_BYTE_CRC0 + 1];
            crc_byte_third   <= tel_buf[`SOTD_BYTE_CRC0 + 2];
            crc_byte_lowest  <= tel_buf[`SOTD_BYTE_CRC0 + 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    logic        aw_held;
    logic        w_held;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire         aw_hs       = s_axi_awvalid & s_axi_awready;
    wire         w_hs        = s_axi_wvalid & s_axi_wready;
    wire         b_hs        = s_axi_bvalid & s_axi_bready;
    wire         have_aw     = aw_held | aw_hs;
    wire         have_w      = w_held | w_hs;
    wire         do_write    = have_aw & have_w & ~s_axi_bvalid;
    wire [11:0]  waddr       = aw_hs ? s_axi_awaddr : awaddr_q;
    wire [31:0]  wdata       = w_hs ? s_axi_wdata : wdata_q;
    wire [3:0]   wstrb       = w_hs ? s_axi_wstrb : wstrb_q;
    wire         next_aw_held = have_aw & ~do_write;
    wire         next_w_held  = have_w & ~do_write;
    wire         next_bvalid  = (s_axi_bvalid & ~b_hs) | do_write;

    wire         wr_mode     = (waddr == `SOTD_OFS_MODE);
    // Read-only registers accept writes silently
    wire         wr_known    = wr_mode
                             | (waddr == `SOTD_OFS_SELECT)
                             | (waddr == `SOTD_OFS_STATUS)
                             | (waddr == `SOTD_OFS_CRC)
                             | (waddr == `SOTD_OFS_FRAMES);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SOTD_RESP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= ~next_aw_held & ~next_bvalid;
            s_axi_wready  <= ~next_w_held & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= wr_known ? `SOTD_RESP_OKAY : `SOTD_RESP_SLVERR;
            end
        end
    end

    // Mode change takes effect on the next completed frame only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode <= sotd_mode_t'(`SOTD_MODE_RESET);
        end else if (do_write && wr_mode && wstrb[0]) begin
            mode <= sotd_mode_t'(wdata[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    wire        ar_hs       = s_axi_arvalid & s_axi_arready;
    wire        r_hs        = s_axi_rvalid & s_axi_rready;
    wire        next_rvalid = (s_axi_rvalid & ~r_hs) | ar_hs;

    wire [31:0] reg_mode   = {30'h0, mode};
    wire [31:0] reg_select = {11'h000, bank_select,
                              3'h0, select_high,
                              3'h0, select_low};
    wire [31:0] reg_status = {15'h0000, mode_error,
                              profile_status,
                              6'h00, restart_protect, restart_warning};
    wire [31:0] reg_crc    = {crc_byte_highest, crc_byte_second,
                              crc_byte_third, crc_byte_lowest};
    wire [31:0] reg_frames = {16'h0000, frame_count};

    logic [31:0] rd_word;
    logic        rd_known;

    always_comb begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        if (s_axi_araddr == `SOTD_OFS_MODE) begin
            rd_word = reg_mode;
        end else if (s_axi_araddr == `SOTD_OFS_SELECT) begin
            rd_word = reg_select;
        end else if (s_axi_araddr == `SOTD_OFS_STATUS) begin
            rd_word = reg_status;
        end else if (s_axi_araddr == `SOTD_OFS_CRC) begin
            rd_word = reg_crc;
        end else if (s_axi_araddr == `SOTD_OFS_FRAMES) begin
            rd_word = reg_frames;
        end else begin
            rd_known = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SOTD_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? `SOTD_RESP_OKAY : `SOTD_RESP_SLVERR;
            end
        end
    end

endmodule : sotd_decoder

// ---- tb/sotd_monitor.sv ----
// Purpose: Port checks for the telegram decoder
// Assumes: One clock, arst_n active low
// Notes:   Attached by bind below
module sotd_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // Telegram
    input wire logic        tel_valid,
    input wire logic [7:0]  tel_data,
    input wire logic        frame_done,
    input wire logic [4:0]  select_low,
    input wire logic [4:0]  select_high,
    input wire logic [4:0]  bank_select,
    input wire logic        restart_warning,
    input wire logic        restart_protect,
    input wire logic [7:0]  crc_byte_lowest,
    input wire logic        mode_error,
    // Register read
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    frame_len_a: assert property (frame_done |-> $past(tel_valid, 2))
        else $error("frame_done without a byte two cycles before");
    crc_order_a: assert property (frame_done |-> crc_byte_lowest == $past(tel_data, 2))
        else $error("lowest CRC byte is not the last byte");
    done_pulse_a: assert property (frame_done |=> !frame_done)
        else $error("frame_done longer than one cycle");
    hold_out_a: assert property ($changed({select_low, select_high, bank_select,
        restart_warning, restart_protect, mode_error}) |-> frame_done)
        else $error("decoded outputs moved between frames");
    mode_excl_a: assert property (!(select_low != 5'h0 && bank_select != 5'h0))
        else $error("field and bank selections both set");
    mode_clear_a: assert property (mode_error |-> !restart_warning && !restart_protect
        && {select_low, select_high, bank_select} == 15'h0)
        else $error("invalid mode left outputs set");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
endmodule : sotd_monitor

bind sotd_decoder sotd_monitor mon_u (.clock(clock), .arst_n(arst_n), .tel_valid(tel_valid),
    .tel_data(tel_data), .frame_done(frame_done), .select_low(select_low),
    .select_high(select_high), .bank_select(bank_select), .mode_error(mode_error),
    .restart_warning(restart_warning), .restart_protect(restart_protect),
    .crc_byte_lowest(crc_byte_lowest), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- tb/sotd_plc_model.sv ----
// Purpose: Safety host sending output telegrams
// Assumes: Bytes launched by NBA after a rising edge
// Notes:   Idle data line shows the inverse of the last byte
module sotd_plc_model
    import sotd_pkg::*;
(
    // Clock
    input  wire logic clock,
    // Telegram stream
    output logic       tel_valid,
    output logic       tel_first,
    output sotd_byte_t tel_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tel_valid = 1'b0;
        tel_first = 1'b0;
        tel_data  = 8'h00;
    end
    // Short last index models a host that gives up mid-frame
    task automatic send(input logic [87:0] frame, input int last, input bit slow);
        for (int i = 0; i <= last; i++) begin
            @(posedge clock);
            tel_valid <= 1'b1;
            tel_first <= (i == 0);
            tel_data  <= frame[8*i +: 8];
            if (slow) begin
                @(posedge clock);
                tel_valid <= 1'b0;
                tel_data  <= ~frame[8*i +: 8];
            end
        end
        @(posedge clock);
        tel_valid <= 1'b0;
        tel_data  <= ~frame[8*last +: 8];
    endtask : send
endmodule : sotd_plc_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the telegram decoder
// Assumes: Register map and bus timing of the decoder
// Notes:   Expected frames and bus answers wait in queues
`include "sotd_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        arst_n;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, s_axi_rdata;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        tel_valid, tel_first, frame_done, mode_error;
    logic        restart_warning, restart_protect;
    logic [7:0]  tel_data, profile_status;
    logic [7:0]  crc_byte_highest, crc_byte_second, crc_byte_third, crc_byte_lowest;
    logic [4:0]  select_low, select_high, bank_select;
    logic [57:0] fq[$];
    logic [33:0] rq[$];
    int          fail_count = 0;
    int          num_checks = 0;

    sotd_plc_model plc_u (.clock, .tel_valid, .tel_first, .tel_data);
    sotd_decoder dut_u (.clock, .arst_n, .tel_valid, .tel_first, .tel_data, .frame_done,
        .select_low, .select_high, .bank_select, .restart_warning, .restart_protect,
        .profile_status, .crc_byte_highest, .crc_byte_second, .crc_byte_third,
        .crc_byte_lowest, .mode_error, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready, .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready));

    always #10 clock = ~clock;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    function automatic logic [57:0] expect_of(input logic [1:0] m, input logic [87:0] f);
        logic [1:0] rs;
        rs = (m == 2'h3) ? 2'h0 : f[33:32];
        return {(m < 2'h2) ? f[4:0] : 5'h0, (m == 2'h1 || m == 2'h2) ? f[20:16] : 5'h0,
            (m == 2'h2) ? f[4:0] : 5'h0, rs[0], rs[1], f[55:48], f[63:56], f[71:64],
            f[79:72], f[87:80], m == 2'h3};
    endfunction : expect_of

    task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        bit pa, pw, lazy;
        pa = 1'b1;
        pw = wr;
        // Late rready on some reads keeps rvalid waiting a cycle
        lazy = !wr && 1'($urandom());
        rq.push_back(e);
        @(posedge clock);
        awaddr  <= a;
        araddr  <= a;
        wdata   <= d;
        awvalid <= wr;
        wvalid  <= wr;
        bready  <= wr;
        arvalid <= !wr;
        rready  <= !wr && !lazy;
        while (pa || pw) begin
            @(posedge clock);
            if (pa && (wr ? s_axi_awready : s_axi_arready) === 1'b1) begin
                pa = 1'b0;
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (pw && s_axi_wready === 1'b1) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        if (lazy) begin
            @(posedge clock);
            rready <= 1'b1;
        end
        do @(posedge clock); while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        bready <= 1'b0;
        rready <= 1'b0;
    endtask : axi
    ////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (frame_done === 1'b1) begin
            check({select_low, select_high, bank_select, restart_warning, restart_protect,
                profile_status, crc_byte_highest, crc_byte_second, crc_byte_third,
                crc_byte_lowest, mode_error}, fq.size() ? fq.pop_front() : 58'h1);
        end
        if ((s_axi_bvalid & bready) === 1'b1) check({s_axi_bresp, 32'h0}, rq.pop_front());
        if ((s_axi_rvalid & rready) === 1'b1) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end

    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_sim();
    end

    initial begin
        logic [87:0] f;
        logic [57:0] e;
        arst_n = 1'b0;
        {awaddr, araddr, wdata} = 56'h0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        void'($urandom(2));
        @(posedge clock);
        check({frame_done, select_low, crc_byte_lowest, mode_error}, 64'h0);
        axi(1'b0, `SOTD_OFS_MODE, 32'h0, {`SOTD_RESP_OKAY, 32'h0});
        for (int i = 0; i < 9; i++) begin
            // Reserved bits stay random so the decoder must ignore them
            for (int b = 0; b < 11; b++) f[8*b +: 8] = 8'($urandom());
            e = expect_of(i[1:0], f);
            axi(1'b1, `SOTD_OFS_MODE, {30'h0, i[1:0]}, {`SOTD_RESP_OKAY, 32'h0});
            if (i == 8) plc_u.send(f, 5, 1'b0);
            fq.push_back(e);
            plc_u.send(f, 10, 1'($urandom()));
            repeat (2) @(posedge clock);
            axi(1'b0, `SOTD_OFS_SELECT, 32'h0, {13'h0, e[47:43], 3'h0, e[52:48], 3'h0,
                e[57:53]});
            axi(1'b0, `SOTD_OFS_STATUS, 32'h0, {17'h0, e[0], e[40:33], 6'h0, e[41],
                e[42]});
            axi(1'b0, `SOTD_OFS_CRC, 32'h0, {2'h0, e[32:1]});
        end
        axi(1'b0, `SOTD_OFS_FRAMES, 32'h0, {`SOTD_RESP_OKAY, 32'h9});
        axi(1'b0, 12'h020, 32'h0, {`SOTD_RESP_SLVERR, 32'h0});
        axi(1'b1, 12'h020, 32'h0, {`SOTD_RESP_SLVERR, 32'h0});
        axi(1'b1, `SOTD_OFS_SELECT, 32'hffff_ffff, {`SOTD_RESP_OKAY, 32'h0});
        // Mode byte lane off: the write is answered but must not land
        wstrb <= 4'he;
        axi(1'b1, `SOTD_OFS_MODE, 32'h3, {`SOTD_RESP_OKAY, 32'h0});
        axi(1'b0, `SOTD_OFS_MODE, 32'h0, {`SOTD_RESP_OKAY, 32'h0});
        axi(1'b0, `SOTD_OFS_SELECT, 32'h0, {13'h0, e[47:43], 3'h0, e[52:48], 3'h0,
            e[57:53]});
        repeat (4) @(posedge clock);
        check(fq.size(), 0);
        end_sim();
    end
endmodule : tb
